// >>> design/tss_top.sv
// Test sequence selection, start source selection and start event qualification.
//
// Function
// - One of ten test kinds is held, driven out with its start voltage when the test starts, and read back.
// - One of six start sources is held and read back.
// - With the manual source, a press of the sequence key starts the test.
// - With the immediate source, the test starts when the instrument leaves idle.
// - The single leave_idle_command command and the continuous-on command both leave idle.
// - With the immediate source applied while not idle, the test starts at once.
// - With the bus source, a bus trigger sent by the host starts the test.
// - With the external source, a rising edge on the external trigger input starts the test.
// - With the linked source, a rising edge on the selected linked trigger line starts the test.
// - With the lid source, a lid closure on an interlocked fixture starts the test.
// - A source change written while a sequence is armed waits until the next arm.
// - A linked trigger line number from 1 to 6 is stored and read back.
// - The stored line number is ignored unless the linked source is active.
// - A start voltage within 100.0 V or 1000 V, by range, is accepted for the sweep tests.
// - After an arm, the block waits for the active source event and then starts the test.
// - Abort stops the sequence, and a new run needs a new arm and a new start event.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_top (
	input  wire logic                   CLK,
	input  wire logic                   RSTN,
	input  wire logic [`TSS_ADDR_W-1:0] ADDR,
	input  wire logic [`TSS_DATA_W-1:0] WDATA,
	input  wire logic                   WR,
	input  wire logic                   RD,
	output logic      [`TSS_DATA_W-1:0] RDATA,
	input  wire logic                   SEQ_KEY,
	input  wire logic                   EXT_TRIG,
	input  wire logic [5:0]             LINK_TRIG,
	input  wire logic                   LID_CLOSED,
	input  wire logic                   LID_INTERLOCK,
	input  wire logic                   TEST_DONE,
	output logic                        TEST_START,
	output logic      [3:0]             TEST_KIND,
	output logic signed [15:0]          START_VOLT,
	output logic                        START_RANGE,
	output logic                        ARMED,
	output logic                        RUNNING
);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// A voltage in tenths of a volt lies inside the limit of the chosen range.
	function automatic logic volt_ok(input logic signed [15:0] v, input logic hi_rng);
		logic signed [15:0] lim;
		lim = hi_rng ? `TSS_VLIM_HI : `TSS_VLIM_LO;
		volt_ok = (v <= lim) && (v >= -lim);
	endfunction : volt_ok

	// A register write hit at a given offset.
	function automatic logic wr_hit(input logic we, input logic [`TSS_ADDR_W-1:0] a,
		input logic [`TSS_ADDR_W-1:0] off);
		wr_hit = we && (a == off);
	endfunction : wr_hit

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// State.

	tss_pkg::tss_state_t st_ff;
	tss_pkg::tss_state_t nxt_st;
	tss_pkg::tss_test_t  test_ff;
	tss_pkg::tss_src_t   src_ff;
	tss_pkg::tss_src_t   pend_src_ff;
	logic                pend_ff;
	logic [2:0]          line_ff;
	logic signed [15:0]  volt_ff;
	logic                rng_ff;
	logic                idle_ff;
	logic                cont_ff;
	logic                err_ff;
	logic                start_ff;
	logic [3:0]          kind_ff;
	logic signed [15:0]  svolt_ff;
	logic                srng_ff;
	logic                armed_ff;
	logic                run_ff;
	logic [`TSS_DATA_W-1:0] rdata_ff;

	logic                wr_ctrl;
	logic                arm_cmd;
	logic                abort_cmd;
	logic                init_cmd;
	logic                bus_trg;
	logic                cont_on;
	logic                cont_off;
	logic                done_cmd;
	logic                done_evt;
	logic                leave_idle;
	logic                bad_wr;
	logic                src_evt;
	logic                go;
	logic [8:0]          lvl;
	logic [8:0]          rise;
	logic [2:0]          line_idx;

	assign wr_ctrl   = wr_hit(WR, ADDR, `TSS_OFF_CTRL);
	assign arm_cmd   = wr_ctrl && WDATA[`TSS_CTRL_ARM];
	assign abort_cmd = wr_ctrl && WDATA[`TSS_CTRL_ABORT];
	assign init_cmd  = wr_ctrl && WDATA[`TSS_CTRL_INIT];
	assign bus_trg   = wr_ctrl && WDATA[`TSS_CTRL_BUSTRG];
	assign cont_on   = wr_ctrl && WDATA[`TSS_CTRL_CONT_ON];
	assign cont_off  = wr_ctrl && WDATA[`TSS_CTRL_CONT_OFF];
	assign done_cmd  = wr_ctrl && WDATA[`TSS_CTRL_DONE];
	assign done_evt  = TEST_DONE || done_cmd;
	assign leave_idle = init_cmd || cont_on;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Start input edges.

	assign lvl = {LID_CLOSED & LID_INTERLOCK, LINK_TRIG, EXT_TRIG, SEQ_KEY};

	tss_edge #(
		.WIDTH(9)
	) u_edge (
		.clk  (CLK),
		.rstn (RSTN),
		.lvl  (lvl),
		.rise (rise)
	);

	// Line numbers are one-based; only a stored value from 1 to 6 can reach here.
	assign line_idx = line_ff - 3'h1;

	// Only the active source is looked at, so the line number matters for the linked source alone.
	always_comb begin
		src_evt = 1'b0;
		unique case (src_ff)
			tss_pkg::TSS_SRC_MANUAL:     src_evt = rise[0];
			tss_pkg::TSS_SRC_IMMEDIATE:  src_evt = !idle_ff;
			tss_pkg::TSS_SRC_BUS:        src_evt = bus_trg;
			tss_pkg::TSS_SRC_EXTERNAL:   src_evt = rise[1];
			tss_pkg::TSS_SRC_LINKED:     src_evt = rise[3'h2 + line_idx];
			tss_pkg::TSS_SRC_LID_CLOSED: src_evt = rise[8];
			default:                     src_evt = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Sequence state machine.

	// Abort outranks a start that qualifies in the same cycle, so no test begins after an abort.
	assign go = (st_ff == tss_pkg::TSS_ST_ARMED) && src_evt && !abort_cmd && !arm_cmd;

	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			tss_pkg::TSS_ST_IDLE: begin
				if (arm_cmd) begin
					nxt_st = tss_pkg::TSS_ST_ARMED;
				end
			end
			tss_pkg::TSS_ST_ARMED: begin
				if (abort_cmd) begin
					nxt_st = tss_pkg::TSS_ST_IDLE;
				end else if (go) begin
					nxt_st = tss_pkg::TSS_ST_RUN;
				end
			end
			tss_pkg::TSS_ST_RUN: begin
				if (abort_cmd || done_evt) begin
					nxt_st = tss_pkg::TSS_ST_IDLE;
				end
			end
			default: nxt_st = tss_pkg::TSS_ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st_ff <= tss_pkg::TSS_ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Measurement idle and continuous mode.

	// Leaving idle wins over a test end in the same cycle.
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			idle_ff <= 1'b1;
			cont_ff <= 1'b0;
		end else begin
			if (cont_on) begin
				cont_ff <= 1'b1;
			end else if (cont_off) begin
				cont_ff <= 1'b0;
			end
			if (leave_idle) begin
				idle_ff <= 1'b0;
			end else if (abort_cmd || cont_off || (done_evt && !cont_ff && st_ff == tss_pkg::TSS_ST_RUN)) begin
				idle_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			test_ff <= tss_pkg::TSS_DIODE_LEAKAGE;
		end else if (wr_hit(WR, ADDR, `TSS_OFF_TYPE) && WDATA[3:0] < `TSS_NUM_TESTS) begin
			test_ff <= tss_pkg::tss_test_t'(WDATA[3:0]);
		end
	end

	// A source written during an armed or running sequence is parked and taken by the next arm.
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			src_ff      <= tss_pkg::TSS_SRC_IMMEDIATE;
			pend_src_ff <= tss_pkg::TSS_SRC_IMMEDIATE;
			pend_ff     <= 1'b0;
		end else if (wr_hit(WR, ADDR, `TSS_OFF_SOURCE) && WDATA[2:0] < `TSS_NUM_SRC) begin
			if (st_ff == tss_pkg::TSS_ST_IDLE) begin
				// A direct write drops any parked source, so a later arm cannot bring back an older choice.
				src_ff  <= tss_pkg::tss_src_t'(WDATA[2:0]);
				pend_ff <= 1'b0;
			end else begin
				pend_src_ff <= tss_pkg::tss_src_t'(WDATA[2:0]);
				pend_ff     <= 1'b1;
			end
		end else if (arm_cmd && pend_ff && st_ff != tss_pkg::TSS_ST_RUN) begin
			src_ff  <= pend_src_ff;
			pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			line_ff <= `TSS_LINE_RST;
		end else if (wr_hit(WR, ADDR, `TSS_OFF_LINE) && WDATA[2:0] >= `TSS_LINE_MIN &&
			WDATA[2:0] <= `TSS_LINE_MAX && WDATA[`TSS_DATA_W-1:3] == '0) begin
			line_ff <= WDATA[2:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			volt_ff <= 16'sh0000;
			rng_ff  <= 1'b0;
		end else if (wr_hit(WR, ADDR, `TSS_OFF_STARTV) &&
			volt_ok($signed(WDATA[15:0]), WDATA[`TSS_STARTV_RANGE])) begin
			volt_ff <= $signed(WDATA[15:0]);
			rng_ff  <= WDATA[`TSS_STARTV_RANGE];
		end
	end

	// Rejected configuration writes leave the old value and raise a sticky flag.
	always_comb begin
		bad_wr = 1'b0;
		if (wr_hit(WR, ADDR, `TSS_OFF_TYPE) && !(WDATA[3:0] < `TSS_NUM_TESTS)) begin
			bad_wr = 1'b1;
		end
		if (wr_hit(WR, ADDR, `TSS_OFF_SOURCE) && !(WDATA[2:0] < `TSS_NUM_SRC)) begin
			bad_wr = 1'b1;
		end
		if (wr_hit(WR, ADDR, `TSS_OFF_LINE) && (WDATA[2:0] < `TSS_LINE_MIN || WDATA[2:0] > `TSS_LINE_MAX ||
			WDATA[`TSS_DATA_W-1:3] != '0)) begin
			bad_wr = 1'b1;
		end
		if (wr_hit(WR, ADDR, `TSS_OFF_STARTV) && !volt_ok($signed(WDATA[15:0]), WDATA[`TSS_STARTV_RANGE])) begin
			bad_wr = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			err_ff <= 1'b0;
		end else if (bad_wr) begin
			err_ff <= 1'b1;
		end else if (wr_ctrl && WDATA[`TSS_CTRL_ERR_CLR]) begin
			err_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Outputs toward the test engine.

	// Test kind and voltage are latched at the start so a later write cannot disturb a running test.
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			start_ff  <= 1'b0;
			kind_ff   <= 4'h0;
			svolt_ff  <= 16'sh0000;
			srng_ff   <= 1'b0;
		end else begin
			start_ff <= go;
			if (go) begin
				kind_ff  <= test_ff;
				svolt_ff <= volt_ff;
				srng_ff  <= rng_ff;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			armed_ff <= 1'b0;
			run_ff   <= 1'b0;
		end else begin
			armed_ff <= (nxt_st == tss_pkg::TSS_ST_ARMED);
			run_ff   <= (nxt_st == tss_pkg::TSS_ST_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Register read port.

	// Read data stand only in the cycle after the strobe and are zero otherwise.
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= '0;
			if (RD) begin
				unique case (ADDR)
					`TSS_OFF_TYPE:   rdata_ff[3:0] <= test_ff;
					`TSS_OFF_SOURCE: rdata_ff[2:0] <= src_ff;
					`TSS_OFF_LINE:   rdata_ff[2:0] <= line_ff;
					`TSS_OFF_STARTV: begin
						rdata_ff[15:0]              <= volt_ff;
						rdata_ff[`TSS_STARTV_RANGE] <= rng_ff;
					end
					`TSS_OFF_STATUS: begin
						rdata_ff[1:0]                      <= st_ff;
						rdata_ff[`TSS_STAT_IDLE]           <= idle_ff;
						rdata_ff[`TSS_STAT_CONT]           <= cont_ff;
						rdata_ff[`TSS_STAT_PEND]           <= pend_ff;
						rdata_ff[`TSS_STAT_ERR]            <= err_ff;
						rdata_ff[`TSS_STAT_PSRC_LO +: 3]   <= pend_src_ff;
					end
					default: rdata_ff <= '0;
				endcase
			end
		end
	end

	assign RDATA       = rdata_ff;
	assign TEST_START  = start_ff;
	assign TEST_KIND   = kind_ff;
	assign START_VOLT  = svolt_ff;
	assign START_RANGE = srng_ff;
	assign ARMED       = armed_ff;
	assign RUNNING     = run_ff;

endmodule : tss_top

// >>> common/tss_consts.svh
// Offsets, field positions, reset values and limits of the test sequence start selector.
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH

`define TSS_ADDR_W          8
`define TSS_DATA_W          32

`define TSS_OFF_CTRL        8'h00
`define TSS_OFF_TYPE        8'h04
`define TSS_OFF_SOURCE      8'h08
`define TSS_OFF_LINE        8'h0C
`define TSS_OFF_STARTV      8'h10
`define TSS_OFF_STATUS      8'h14

`define TSS_CTRL_ARM        0
`define TSS_CTRL_ABORT      1
`define TSS_CTRL_INIT       2
`define TSS_CTRL_BUSTRG     3
`define TSS_CTRL_CONT_ON    4
`define TSS_CTRL_CONT_OFF   5
`define TSS_CTRL_DONE       6
`define TSS_CTRL_ERR_CLR    7

`define TSS_STARTV_RANGE    16
`define TSS_STAT_IDLE       2
`define TSS_STAT_CONT       3
`define TSS_STAT_PEND       4
`define TSS_STAT_ERR        5
`define TSS_STAT_PSRC_LO    8

`define TSS_LINE_MIN        3'h1
`define TSS_LINE_MAX        3'h6
`define TSS_LINE_RST        3'h1
`define TSS_NUM_LINES       6
`define TSS_NUM_TESTS       4'hA
`define TSS_NUM_SRC         3'h6

// Start voltage is held in tenths of a volt.
`define TSS_VLIM_LO_V       100.0
`define TSS_VLIM_HI_V       1000
`define TSS_VLIM_LO         16'sd1000
`define TSS_VLIM_HI         16'sd10000

`endif

// >>> common/tss_pkg.sv
// Types of the test sequence start selector.
package tss_pkg;

	typedef enum logic [3:0] {
		TSS_DIODE_LEAKAGE   = 4'h0,
		TSS_CAP_LEAKAGE     = 4'h1,
		TSS_CABLE_INSUL     = 4'h2,
		TSS_RES_VCOEFF      = 4'h3,
		TSS_SURF_RESIST     = 4'h4,
		TSS_VOL_RESIST      = 4'h5,
		TSS_SURF_INSUL      = 4'h6,
		TSS_SQUARE_SWEEP    = 4'h7,
		TSS_STAIR_SWEEP     = 4'h8,
		TSS_ALT_POLARITY    = 4'h9
	} tss_test_t;

	typedef enum logic [2:0] {
		TSS_SRC_MANUAL      = 3'h0,
		TSS_SRC_IMMEDIATE   = 3'h1,
		TSS_SRC_BUS         = 3'h2,
		TSS_SRC_EXTERNAL    = 3'h3,
		TSS_SRC_LINKED      = 3'h4,
		TSS_SRC_LID_CLOSED  = 3'h5
	} tss_src_t;

	typedef enum logic [1:0] {
		TSS_ST_IDLE         = 2'h0,
		TSS_ST_ARMED        = 2'h1,
		TSS_ST_RUN          = 2'h3
	} tss_state_t;

endpackage : tss_pkg

// >>> design/tss_edge.sv
// Rising edge detector for a group of synchronous start inputs.
`timescale 1ns/1ps

module tss_edge #(
	parameter int WIDTH = 9
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] lvl,
	output logic      [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] prev_ff;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// A level already high at reset release does not count as an event.
			always_ff @(posedge clk) begin
				if (!rstn) begin
					prev_ff[g] <= 1'b1;
				end else begin
					prev_ff[g] <= lvl[g];
				end
			end
			assign rise[g] = lvl[g] & ~prev_ff[g];
		end
	endgenerate

endmodule : tss_edge

// >>> tb/tss_top_checker.sv
// Concurrent checks on the ports of the test sequence start selector.
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_top_checker (
	input wire logic                   CLK,
	input wire logic                   RSTN,
	input wire logic [`TSS_ADDR_W-1:0] ADDR,
	input wire logic [`TSS_DATA_W-1:0] WDATA,
	input wire logic                   WR,
	input wire logic                   RD,
	input wire logic [`TSS_DATA_W-1:0] RDATA,
	input wire logic                   TEST_DONE,
	input wire logic                   TEST_START,
	input wire logic [3:0]             TEST_KIND,
	input wire logic signed [15:0]     START_VOLT,
	input wire logic                   START_RANGE,
	input wire logic                   ARMED,
	input wire logic                   RUNNING
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	AST_START_ONE: assert property (TEST_START |=> !TEST_START)
		else $error("start pulse longer than one cycle");
	AST_START_ARMED: assert property (TEST_START |-> $past(ARMED) && !$past(RUNNING))
		else $error("start without armed state");
	AST_START_RUN: assert property (TEST_START |-> RUNNING && !ARMED)
		else $error("start without running state");
	AST_RUN_ROSE: assert property ($rose(RUNNING) |-> TEST_START)
		else $error("running without start pulse");
	AST_DONE_STOP: assert property (RUNNING && TEST_DONE |=> !RUNNING)
		else $error("running after test done");
	AST_ABORT_STOP: assert property (WR && ADDR == `TSS_OFF_CTRL && WDATA[`TSS_CTRL_ABORT] |=> !RUNNING && !ARMED)
		else $error("sequence alive after abort");
	AST_KIND_HOLD: assert property (RUNNING && !TEST_START |-> $stable(TEST_KIND) && $stable(START_VOLT))
		else $error("test setup changed while running");
	AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == '0)
		else $error("read data outside read cycle");
	AST_CTRL_WO: assert property (RD && ADDR == `TSS_OFF_CTRL |=> RDATA == '0)
		else $error("control register read not zero");
endmodule : tss_top_checker

bind tss_top tss_top_checker chk_i (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .TEST_DONE(TEST_DONE), .TEST_START(TEST_START), .TEST_KIND(TEST_KIND),
	.START_VOLT(START_VOLT), .START_RANGE(START_RANGE), .ARMED(ARMED), .RUNNING(RUNNING));

// >>> tb/tss_host_model.sv
// Host model driving the register port of the start selector.
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_host_model (
	input  wire logic                   CLK,
	output logic      [`TSS_ADDR_W-1:0] ADDR,
	output logic      [`TSS_DATA_W-1:0] WDATA,
	output logic                        WR,
	output logic                        RD,
	input  wire logic [`TSS_DATA_W-1:0] RDATA
);
	initial begin
		ADDR  = '0;
		WDATA = '0;
		WR    = 1'b0;
		RD    = 1'b0;
	end

	// Address and data are inverted after each write strobe so stale values never look valid.
	task wr(input logic [`TSS_ADDR_W-1:0] a, input logic [`TSS_DATA_W-1:0] d);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR    <= 1'b0;
		ADDR  <= ~a;
		WDATA <= ~d;
	endtask : wr

	task rd(input logic [`TSS_ADDR_W-1:0] a, output logic [`TSS_DATA_W-1:0] d);
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLK);
		RD   <= 1'b0;
		ADDR <= ~a;
		#1;
		d = RDATA;
	endtask : rd

	task trg;
		wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_BUSTRG);
	endtask : trg
endmodule : tss_host_model

// >>> tb/tss_top_tb_top.sv
// Self-checking bench for the test sequence start selector.
`timescale 1ns/1ps
`include "tss_consts.svh"

module tss_top_tb_top;
	logic                   clk;
	logic                   rstn;
	logic [`TSS_ADDR_W-1:0] addr;
	logic [`TSS_DATA_W-1:0] wdata;
	logic                   wr;
	logic                   rd;
	logic [`TSS_DATA_W-1:0] rdata;
	logic [8:0]             ev;
	logic                   ilk;
	logic                   done;
	logic                   start;
	logic [3:0]             kind;
	logic signed [15:0]     volt;
	logic                   rng;
	logic                   armed;
	logic                   running;
	logic [31:0]            rv;
	int                     fail_count;
	int                     checked;
	int                     kc;
	int                     starts;
	logic [31:0]            sv_exp;

	tss_top uut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SEQ_KEY(ev[0]), .EXT_TRIG(ev[1]), .LINK_TRIG(ev[7:2]), .LID_CLOSED(ev[8]), .LID_INTERLOCK(ilk),
		.TEST_DONE(done), .TEST_START(start), .TEST_KIND(kind), .START_VOLT(volt), .START_RANGE(rng),
		.ARMED(armed), .RUNNING(running));
	tss_host_model host (.CLK(clk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Start pulses are counted at the falling edge, where the registered output has settled.
	always @(negedge clk) begin
		if (start === 1'b1) begin
			starts <= starts + 1;
		end
	end

	task stop_test;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task rchk(input logic [7:0] a, input logic [31:0] e);
		host.rd(a, rv);
		chk(rv, e);
	endtask : rchk

	// Index 0 key, 1 external, 2 to 7 linked lines 1 to 6, 8 lid.
	task kick(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
	endtask : kick

	task expect_run(input logic e);
		int n0;
		n0 = starts;
		repeat (4) @(posedge clk);
		#1;
		chk(running, e);
		chk(starts - n0, e);
		if (e) begin
			chk(kind, kc % 10);
			chk({15'h0, rng, volt}, sv_exp);
		end
	endtask : expect_run

	// Abort together with continuous-off ends continuous mode so every case starts from idle.
	task fin;
		@(posedge clk);
		done <= 1'b1;
		ev   <= '0;
		@(posedge clk);
		done <= 1'b0;
		host.wr(`TSS_OFF_CTRL, 32'h0000_0022);
		#1;
		chk(running, 1'b0);
	endtask : fin

	task run(input logic [2:0] s, input logic [2:0] ln, input int i, input logic lk, input logic e);
		kc++;
		ilk <= lk;
		host.wr(`TSS_OFF_SOURCE, {29'h0, s});
		host.wr(`TSS_OFF_LINE, {29'h0, ln});
		host.wr(`TSS_OFF_TYPE, kc % 10);
		if (i == 12) host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_CONT_ON);
		host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_ARM);
		case (i)
			9: host.trg();
			10: host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_INIT);
			11: host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_CONT_ON);
			default: if (i < 9) kick(i);
		endcase
		expect_run(e);
		fin;
	endtask : run

	initial begin
		#50000;
		fail_count++;
		stop_test();
	end

	initial begin
		rstn       = 1'b0;
		ev         = '0;
		ilk        = 1'b0;
		done       = 1'b0;
		fail_count = 0;
		checked    = 0;
		kc         = 0;
		starts     = 0;
		sv_exp     = 32'h0000_FC18;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rchk(`TSS_OFF_TYPE, 32'h0);
		rchk(`TSS_OFF_SOURCE, 32'h1);
		rchk(`TSS_OFF_LINE, 32'h1);
		rchk(`TSS_OFF_STARTV, 32'h0);
		rchk(`TSS_OFF_CTRL, 32'h0);
		host.wr(8'h18, 32'hFFFF_FFFF);
		rchk(8'h18, 32'h0);
		for (int i = 0; i < 11; i++) begin
			host.wr(`TSS_OFF_TYPE, i);
			rchk(`TSS_OFF_TYPE, (i > 9) ? 9 : i);
		end
		for (int i = 0; i < 7; i++) begin
			host.wr(`TSS_OFF_SOURCE, i);
			rchk(`TSS_OFF_SOURCE, (i > 5) ? 5 : i);
		end
		for (int i = 0; i < 8; i++) begin
			host.wr(`TSS_OFF_LINE, i);
			rchk(`TSS_OFF_LINE, (i == 0) ? 1 : ((i > 6) ? 6 : i));
		end
		host.wr(`TSS_OFF_STARTV, 32'h0000_03E8);
		rchk(`TSS_OFF_STARTV, 32'h0000_03E8);
		host.wr(`TSS_OFF_STARTV, 32'h0000_03E9);
		rchk(`TSS_OFF_STARTV, 32'h0000_03E8);
		host.wr(`TSS_OFF_STARTV, 32'h0001_2710);
		rchk(`TSS_OFF_STARTV, 32'h0001_2710);
		host.wr(`TSS_OFF_STARTV, 32'h0000_FC18);
		rchk(`TSS_OFF_STARTV, 32'h0000_FC18);
		rchk(`TSS_OFF_STATUS, 32'h0000_0124);
		host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_ERR_CLR);
		rchk(`TSS_OFF_STATUS, 32'h0000_0104);
		$display("test registers done");
		run(3'h0, 3'h1, 0, 1'b0, 1'b1);
		run(3'h0, 3'h1, 1, 1'b0, 1'b0);
		run(3'h1, 3'h1, 13, 1'b0, 1'b0);
		run(3'h1, 3'h1, 10, 1'b0, 1'b1);
		run(3'h1, 3'h1, 11, 1'b0, 1'b1);
		run(3'h1, 3'h1, 12, 1'b0, 1'b1);
		run(3'h2, 3'h1, 9, 1'b0, 1'b1);
		run(3'h2, 3'h1, 1, 1'b0, 1'b0);
		run(3'h3, 3'h1, 1, 1'b0, 1'b1);
		run(3'h4, 3'h3, 4, 1'b0, 1'b1);
		run(3'h4, 3'h3, 2, 1'b0, 1'b0);
		run(3'h4, 3'h6, 7, 1'b0, 1'b1);
		run(3'h3, 3'h3, 4, 1'b0, 1'b0);
		run(3'h5, 3'h1, 8, 1'b1, 1'b1);
		run(3'h5, 3'h1, 8, 1'b0, 1'b0);
		$display("test start sources done");
		host.wr(`TSS_OFF_SOURCE, 32'h2);
		host.wr(`TSS_OFF_CTRL, 32'h1);
		host.wr(`TSS_OFF_SOURCE, 32'h3);
		rchk(`TSS_OFF_STATUS, 32'h0000_0315);
		kick(1);
		expect_run(1'b0);
		host.trg();
		expect_run(1'b1);
		fin;
		host.wr(`TSS_OFF_CTRL, 32'h1);
		kick(1);
		expect_run(1'b1);
		fin;
		kick(1);
		expect_run(1'b0);
		fin;
		$display("test pending source done");
		host.wr(`TSS_OFF_STARTV, 32'h0001_2710);
		sv_exp = 32'h0001_2710;
		host.wr(`TSS_OFF_CTRL, 32'h1);
		kick(1);
		expect_run(1'b1);
		host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_DONE);
		#1;
		chk(running, 1'b0);
		@(posedge clk);
		ev <= '0;
		host.wr(`TSS_OFF_CTRL, 32'h1);
		kick(1);
		expect_run(1'b1);
		host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_ABORT);
		#1;
		chk(running, 1'b0);
		fin;
		host.wr(`TSS_OFF_CTRL, 32'h1);
		host.wr(`TSS_OFF_SOURCE, 32'h2);
		host.wr(`TSS_OFF_CTRL, 32'h1 << `TSS_CTRL_ABORT);
		host.wr(`TSS_OFF_SOURCE, 32'h4);
		host.wr(`TSS_OFF_CTRL, 32'h1);
		rchk(`TSS_OFF_SOURCE, 32'h4);
		fin;
		$display("test run control done");
		stop_test();
	end
endmodule : tss_top_tb_top
